// ---- hw/bit_branch_pkg.sv ----
/*
  shared constants for the bit manipulation and branch unit:
  opcodes, opcode patterns, byte lengths, cycle counts, flag positions.
  assumes the status byte is ordered N V G B H I Z C from bit 7 down.
*/
`default_nettype none
package bit_branch_pkg;
  // ---------------------------------------------------------------
  // status flag positions
  // ---------------------------------------------------------------
  localparam int FLAG_N = 7;
  localparam int FLAG_V = 6;
  localparam int FLAG_G = 5;
  localparam int FLAG_H = 3;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;
  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_CARRY_AND = 8'h8b;
  localparam logic [7:0] OP_CARRY_OR = 8'h6b;
  localparam logic [7:0] OP_CARRY_XOR = 8'hab;
  localparam logic [7:0] OP_LOAD_CARRY = 8'hcb;
  localparam logic [7:0] OP_BIT_TEST_DP = 8'h0c;
  localparam logic [7:0] OP_BIT_TEST_ABS = 8'h1c;
  localparam logic [7:0] OP_ACCUM_BIT_CLEAR = 8'h2b;
  localparam logic [7:0] OP_ACCUM_BIT_SET = 8'h0b;
  localparam logic [7:0] OP_CARRY_CLEAR = 8'h20;
  localparam logic [7:0] OP_CARRY_SET = 8'ha0;
  localparam logic [7:0] OP_PAGE_FLAG_CLEAR = 8'h40;
  localparam logic [7:0] OP_PAGE_FLAG_SET = 8'hc0;
  localparam logic [7:0] OP_OVERFLOW_CLEAR = 8'h80;
  localparam logic [7:0] OP_MEMORY_BIT_INVERT = 8'h4b;
  localparam logic [7:0] OP_STORE_CARRY = 8'heb;
  localparam logic [7:0] OP_TEST_AND_CLEAR = 8'h5c;
  localparam logic [7:0] OP_TEST_AND_SET = 8'h3c;
  localparam logic [7:0] OP_BRANCH_CARRY_LOW = 8'h50;
  localparam logic [7:0] OP_BRANCH_CARRY_HIGH = 8'hd0;
  localparam logic [7:0] OP_BRANCH_NONZERO = 8'h70;
  localparam logic [7:0] OP_BRANCH_NEGATIVE = 8'h90;
  localparam logic [7:0] OP_BRANCH_POSITIVE = 8'h10;
  // bit number in opcode[7:5]; opcode[4] high for clear/low-branch
  localparam logic [7:0] PAT_BIT_FORM_1 = 8'b???0_0001;
  localparam logic [7:0] PAT_BIT_FORM_2 = 8'b???0_0010;
  localparam logic [7:0] PAT_BIT_FORM_3 = 8'b???0_0011;
  localparam int OPC_LOW_SEL = 4;
  // ---------------------------------------------------------------
  // lengths and cycle counts
  // ---------------------------------------------------------------
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_4 = 4'h4;
  localparam logic [3:0] CYC_5 = 4'h5;
  localparam logic [3:0] CYC_6 = 4'h6;
  localparam logic [3:0] CYC_7 = 4'h7;
  // ---------------------------------------------------------------
  // memory-bit operand layout {operand2, operand1}
  // ---------------------------------------------------------------
  localparam int MBIT_NUM_LSB = 13;
  localparam int MBIT_INV_POS = 12;
  localparam int MBIT_ADDR_MSB = 11;
  localparam logic [7:0] DP_PAGE_HIGH = 8'h01;
  localparam logic [15:0] RESET_PC = 16'h0000;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_BUSY = 1'b1} exec_state_type;
endpackage : bit_branch_pkg
`default_nettype wire

// ---- hw/bit_ops_branch_unit.sv ----
/*
  execution unit for single-bit manipulation and relative branches.
  assumes the fetch stage hands over opcode, operands, accumulator,
  status, opcode address and the byte at the effective address with
  i_start; an i_start while o_busy is high is ignored.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_ops_branch_unit
#(
  parameter logic [7:0] BRANCH_ZERO_OPCODE = 8'hf0
)
(
  input wire logic i_core_clk, // 20 MHz core clock
  input wire logic i_reset, // synchronous, active high
  input wire logic i_start, // one-cycle instruction hand-over
  input wire logic [7:0] i_opcode, // instruction opcode
  input wire logic [7:0] i_operand1, // first operand byte
  input wire logic [7:0] i_operand2, // second operand byte
  input wire logic [7:0] i_acc, // accumulator before
  input wire logic [7:0] i_psw, // status before
  input wire logic [15:0] i_pc, // address of the opcode
  input wire logic [7:0] i_mem_data, // byte at effective address
  output logic o_busy, // instruction in progress
  output logic o_done, // last cycle of instruction
  output logic o_illegal, // opcode not served here
  output logic [7:0] o_acc, // accumulator after
  output logic [7:0] o_psw, // status after
  output logic [15:0] o_pc, // next program counter
  output logic o_mem_we, // write pulse in last cycle
  output logic [15:0] o_mem_addr, // effective address
  output logic [7:0] o_mem_wdata // byte to write
);
  import bit_branch_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (BRANCH_ZERO_OPCODE == OP_BRANCH_CARRY_HIGH || BRANCH_ZERO_OPCODE == OP_BRANCH_NONZERO
      || BRANCH_ZERO_OPCODE[3:0] == 4'h1 || BRANCH_ZERO_OPCODE[3:0] == 4'h2
      || BRANCH_ZERO_OPCODE[3:0] == 4'h3)
  begin : g_bad_opcode
    $error("branch on zero opcode collides with another opcode");
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  exec_state_type state;
  logic [3:0] cnt;
  logic pend_we;
  logic accepted;
  logic [2:0] opc_bit;
  logic [2:0] mbit_num;
  logic mbit_inv;
  logic mem_bit;
  logic [15:0] mbit_addr;
  logic [15:0] dp_addr;
  logic [15:0] abs_addr;
  logic [15:0] seq_pc;
  logic [15:0] tgt_pc;
  logic [7:0] rel;
  logic [7:0] diff;
  logic [1:0] len;
  logic taken;
  logic branch;
  logic [7:0] next_acc;
  logic [7:0] next_psw;
  logic [15:0] next_pc;
  logic next_we;
  logic [15:0] next_addr;
  logic [7:0] next_wdata;
  logic [3:0] next_cycles;
  logic next_illegal;

  assign accepted = i_start && (state == ST_IDLE);
  assign opc_bit = i_opcode[7:5];
  // the bit-address operand carries bit number, invert selector, address
  assign mbit_num = i_operand2[MBIT_NUM_LSB-8 +: 3];
  assign mbit_inv = i_operand2[MBIT_INV_POS-8];
  assign mem_bit = i_mem_data[mbit_num] ^ mbit_inv;
  assign mbit_addr = {4'h0, i_operand2[MBIT_ADDR_MSB-8:0], i_operand1};
  // the page flag moves the direct page up by one 256-byte page
  assign dp_addr = {(i_psw[FLAG_G] ? DP_PAGE_HIGH : 8'h00), i_operand1};
  assign abs_addr = {i_operand2, i_operand1};
  assign diff = i_acc - i_mem_data;
  assign seq_pc = i_pc + {14'h0000, len};
  assign tgt_pc = seq_pc + {{8{rel[7]}}, rel};

  always_comb
  begin
    next_acc = i_acc;
    next_psw = i_psw;
    next_we = 1'b0;
    next_addr = mbit_addr;
    next_wdata = i_mem_data;
    next_cycles = CYC_2;
    next_illegal = 1'b0;
    len = LEN_1;
    rel = i_operand1;
    taken = 1'b0;
    branch = 1'b0;
    casez (i_opcode)
      OP_CARRY_AND:
      begin
        next_psw[FLAG_C] = i_psw[FLAG_C] & mem_bit;
        len = LEN_3;
        next_cycles = CYC_4;
      end
      OP_CARRY_OR:
      begin
        next_psw[FLAG_C] = i_psw[FLAG_C] | mem_bit;
        len = LEN_3;
        next_cycles = CYC_5;
      end
      OP_CARRY_XOR:
      begin
        next_psw[FLAG_C] = i_psw[FLAG_C] ^ mem_bit;
        len = LEN_3;
        next_cycles = CYC_5;
      end
      OP_LOAD_CARRY:
      begin
        next_psw[FLAG_C] = mem_bit;
        len = LEN_3;
        next_cycles = CYC_4;
      end
      OP_BIT_TEST_DP, OP_BIT_TEST_ABS:
      begin
        next_psw[FLAG_Z] = ((i_acc & i_mem_data) == 8'h00);
        next_psw[FLAG_N] = i_mem_data[7];
        next_psw[FLAG_V] = i_mem_data[6];
        next_addr = i_opcode[4] ? abs_addr : dp_addr;
        len = i_opcode[4] ? LEN_3 : LEN_2;
        next_cycles = i_opcode[4] ? CYC_5 : CYC_4;
      end
      // bit 4 is spliced in: or-ing a wildcard pattern would turn its wildcard bits into x
      PAT_BIT_FORM_1, {PAT_BIT_FORM_1[7:5], 1'b1, PAT_BIT_FORM_1[3:0]}:
      begin
        next_wdata[opc_bit] = ~i_opcode[OPC_LOW_SEL];
        next_we = 1'b1;
        next_addr = dp_addr;
        len = LEN_2;
        next_cycles = CYC_4;
      end
      OP_ACCUM_BIT_CLEAR, OP_ACCUM_BIT_SET:
      begin
        next_acc[i_operand1[2:0]] = ~i_opcode[OPC_LOW_SEL+1];
        len = LEN_2;
      end
      OP_CARRY_CLEAR, OP_CARRY_SET:
        next_psw[FLAG_C] = i_opcode[7];
      OP_PAGE_FLAG_CLEAR, OP_PAGE_FLAG_SET:
        next_psw[FLAG_G] = i_opcode[7];
      OP_OVERFLOW_CLEAR:
      begin
        next_psw[FLAG_V] = 1'b0;
        next_psw[FLAG_H] = 1'b0;
      end
      OP_MEMORY_BIT_INVERT:
      begin
        next_wdata[mbit_num] = ~i_mem_data[mbit_num];
        next_we = 1'b1;
        len = LEN_3;
        next_cycles = CYC_5;
      end
      OP_STORE_CARRY:
      begin
        next_wdata[mbit_num] = i_psw[FLAG_C];
        next_we = 1'b1;
        len = LEN_3;
        next_cycles = CYC_6;
      end
      OP_TEST_AND_CLEAR, OP_TEST_AND_SET:
      begin
        next_psw[FLAG_N] = diff[7];
        next_psw[FLAG_Z] = (diff == 8'h00);
        next_wdata = i_opcode[6] ? (i_mem_data & ~i_acc) : (i_mem_data | i_acc);
        next_we = 1'b1;
        next_addr = abs_addr;
        len = LEN_3;
        next_cycles = CYC_6;
      end
      PAT_BIT_FORM_2, {PAT_BIT_FORM_2[7:5], 1'b1, PAT_BIT_FORM_2[3:0]}:
      begin
        branch = 1'b1;
        taken = i_acc[opc_bit] ^ i_opcode[OPC_LOW_SEL];
        len = LEN_2;
        next_cycles = taken ? CYC_6 : CYC_4;
      end
      PAT_BIT_FORM_3, {PAT_BIT_FORM_3[7:5], 1'b1, PAT_BIT_FORM_3[3:0]}:
      begin
        branch = 1'b1;
        taken = i_mem_data[opc_bit] ^ i_opcode[OPC_LOW_SEL];
        rel = i_operand2;
        next_addr = dp_addr;
        len = LEN_3;
        next_cycles = taken ? CYC_7 : CYC_5;
      end
      OP_BRANCH_CARRY_LOW, OP_BRANCH_CARRY_HIGH:
      begin
        branch = 1'b1;
        taken = i_psw[FLAG_C] == i_opcode[7];
        len = LEN_2;
        next_cycles = taken ? CYC_4 : CYC_2;
      end
      OP_BRANCH_NONZERO, BRANCH_ZERO_OPCODE:
      begin
        branch = 1'b1;
        taken = i_psw[FLAG_Z] == (i_opcode != OP_BRANCH_NONZERO);
        len = LEN_2;
        next_cycles = taken ? CYC_4 : CYC_2;
      end
      OP_BRANCH_NEGATIVE, OP_BRANCH_POSITIVE:
      begin
        branch = 1'b1;
        taken = i_psw[FLAG_N] == i_opcode[7];
        len = LEN_2;
        next_cycles = taken ? CYC_4 : CYC_2;
      end
      default:
        next_illegal = 1'b1;
    endcase
    next_pc = (branch && taken) ? tgt_pc : seq_pc;
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  // results are fixed at hand-over; the count only paces completion
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (accepted)
          begin
            state <= ST_BUSY;
            cnt <= next_cycles - 4'h1;
            o_busy <= 1'b1;
          end
        ST_BUSY:
        begin
          cnt <= cnt - 4'h1;
          o_done <= (cnt == 4'h1);
          if (cnt == 4'h0)
          begin
            state <= ST_IDLE;
            o_busy <= 1'b0;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // memory write lands in the last cycle, after flags are final
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      pend_we <= 1'b0;
      o_mem_we <= 1'b0;
    end
    else
    begin
      if (accepted)
        pend_we <= next_we;
      o_mem_we <= pend_we && (state == ST_BUSY) && (cnt == 4'h1);
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_acc <= 8'h00;
      o_psw <= 8'h00;
      o_pc <= RESET_PC;
      o_mem_addr <= 16'h0000;
      o_mem_wdata <= 8'h00;
      o_illegal <= 1'b0;
    end
    else if (accepted)
    begin
      o_acc <= next_acc;
      o_psw <= next_psw;
      o_pc <= next_pc;
      o_mem_addr <= next_addr;
      o_mem_wdata <= next_wdata;
      o_illegal <= next_illegal;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  logic [1:0] mem_top;
  logic [6:0] psw_upper;
  assign mem_top = i_mem_data[7:6];
  assign psw_upper = i_psw[7:1];

  chk_carry_and_low: assert property (accepted && i_opcode == OP_CARRY_AND && !i_psw[FLAG_C]
    |-> ##4 o_done && !o_psw[FLAG_C]) else $error("carry and left carry set");
  chk_carry_or_high: assert property (accepted && i_opcode == OP_CARRY_OR && i_psw[FLAG_C]
    |-> ##5 o_done && o_psw[FLAG_C]) else $error("carry or lost carry");
  chk_carry_xor_len: assert property (accepted && i_opcode == OP_CARRY_XOR
    |=> o_busy[*5] ##1 !o_busy) else $error("carry xor busy length wrong");
  chk_load_carry: assert property (accepted && i_opcode == OP_LOAD_CARRY
    |-> ##4 o_done && o_psw[FLAG_C] == $past(mem_bit, 4)) else $error("load carry value wrong");
  chk_bit_test_flags: assert property (accepted && i_opcode == OP_BIT_TEST_DP
    |-> ##4 o_done && o_psw[7:6] == $past(mem_top, 4)) else $error("bit test flags wrong");
  chk_carry_clear: assert property (accepted && i_opcode == OP_CARRY_CLEAR
    |-> ##2 o_done && !o_psw[FLAG_C] && o_psw[7:1] == $past(psw_upper, 2)) else $error("carry clear wrong");
  chk_store_carry_we: assert property (accepted && i_opcode == OP_STORE_CARRY
    |-> !o_mem_we[*6] ##1 (o_mem_we && o_done)) else $error("store carry write timing wrong");
  chk_branch_untaken: assert property (accepted && i_opcode == OP_BRANCH_CARRY_LOW && i_psw[FLAG_C]
    |-> ##2 o_done && o_pc == $past(seq_pc, 2)) else $error("untaken branch wrong");
  chk_branch_taken: assert property (accepted && branch && taken && len == LEN_2 && i_opcode[3:0] == 4'h0
    |-> ##4 o_done && o_pc == $past(tgt_pc, 4)) else $error("taken branch wrong");
  chk_done_busy: assert property (o_done |-> o_busy ##1 !o_done) else $error("done outside busy");

  cov_taken_branch: cover property (accepted && branch && taken);
  cov_bit_write: cover property (accepted && next_we ##[2:7] o_mem_we);
  cov_back_to_back: cover property (o_busy ##1 !o_busy && accepted);
endmodule : bit_ops_branch_unit
`default_nettype wire

// ---- verif/bit_ops_branch_unit_bench.sv ----
/*
  self-checking bench for bit_ops_branch_unit: fixed corner cases, then
  random instructions, each compared with a reference model.
  assumes the unit's package and its i_start / o_busy hand-over.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_ops_branch_unit_bench;
  import bit_branch_pkg::*;
  localparam logic [7:0] BZ = 8'hf0;
  localparam int LIMIT = 20000;
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] psw;
    logic [15:0] pc;
    logic we;
    logic ill;
    logic [15:0] addr;
    logic [15:0] am;
    logic [7:0] wd;
    logic [3:0] cyc;
  } exp_type;
  localparam logic [7:0] OPS [21] = '{OP_CARRY_AND, OP_CARRY_OR, OP_CARRY_XOR, OP_LOAD_CARRY, OP_BIT_TEST_DP,
    OP_BIT_TEST_ABS, OP_ACCUM_BIT_CLEAR, OP_ACCUM_BIT_SET, OP_CARRY_CLEAR, OP_CARRY_SET, OP_PAGE_FLAG_CLEAR,
    OP_PAGE_FLAG_SET, OP_OVERFLOW_CLEAR, OP_MEMORY_BIT_INVERT, OP_STORE_CARRY, OP_TEST_AND_CLEAR,
    OP_TEST_AND_SET, OP_BRANCH_CARRY_LOW, OP_BRANCH_CARRY_HIGH, OP_BRANCH_NONZERO, BZ};
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_start = 1'b0;
  logic [7:0] i_opcode = 8'h00;
  logic [7:0] i_operand1 = 8'h00;
  logic [7:0] i_operand2 = 8'h00;
  logic [7:0] i_acc = 8'h00;
  logic [7:0] i_psw = 8'h00;
  logic [15:0] i_pc = 16'h0000;
  logic [7:0] i_mem_data = 8'h00;
  logic o_busy, o_done, o_illegal, o_mem_we;
  logic [7:0] o_acc, o_psw, o_mem_wdata;
  logic [15:0] o_pc, o_mem_addr;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int k;
  logic [7:0] op;
  logic [7:0] o2;

  always #25 i_core_clk = ~i_core_clk;

  bit_ops_branch_unit #(.BRANCH_ZERO_OPCODE(BZ)) DUT (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_start(i_start), .i_opcode(i_opcode), .i_operand1(i_operand1), .i_operand2(i_operand2), .i_acc(i_acc),
    .i_psw(i_psw), .i_pc(i_pc), .i_mem_data(i_mem_data), .o_busy(o_busy), .o_done(o_done),
    .o_illegal(o_illegal), .o_acc(o_acc), .o_psw(o_psw), .o_pc(o_pc), .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata));

  // ------------------------------
  // reference model
  // ------------------------------
  function automatic exp_type model(input logic [7:0] op, o1, o2, a, p, m, input logic [15:0] pc);
    exp_type r;
    logic [15:0] dp;
    logic [7:0] rel;
    logic [7:0] d;
    logic [2:0] bn;
    logic b;
    logic tk;
    logic [1:0] len;
    bn = o2[7:5];
    b = m[bn] ^ o2[4];
    dp = {p[FLAG_G] ? 8'h01 : 8'h00, o1};
    d = a - m;
    rel = o1;
    tk = 1'b0;
    len = LEN_3;
    r = '{a, p, 16'h0000, 1'b0, 1'b0, {4'h0, o2[3:0], o1}, 16'h0fff, m, CYC_5};
    casez (op)
      OP_CARRY_AND, OP_LOAD_CARRY:
      begin
        r.psw[FLAG_C] = op[6] ? b : p[FLAG_C] & b;
        r.cyc = CYC_4;
      end
      OP_CARRY_OR: r.psw[FLAG_C] = p[FLAG_C] | b;
      OP_CARRY_XOR: r.psw[FLAG_C] = p[FLAG_C] ^ b;
      OP_MEMORY_BIT_INVERT, OP_STORE_CARRY:
      begin
        r.we = 1'b1;
        r.wd[bn] = op[5] ? p[FLAG_C] : ~m[bn];
        r.cyc = op[5] ? CYC_6 : CYC_5;
      end
      OP_BIT_TEST_DP, OP_BIT_TEST_ABS:
      begin
        r.psw[FLAG_Z] = (a & m) == 8'h00;
        r.psw[FLAG_N] = m[7];
        r.psw[FLAG_V] = m[6];
        r.addr = op[4] ? {o2, o1} : dp;
        r.am = 16'hffff;
        len = op[4] ? LEN_3 : LEN_2;
        r.cyc = op[4] ? CYC_5 : CYC_4;
      end
      OP_TEST_AND_CLEAR, OP_TEST_AND_SET:
      begin
        r.psw[FLAG_N] = d[7];
        r.psw[FLAG_Z] = d == 8'h00;
        r.we = 1'b1;
        r.wd = op[5] ? m | a : m & ~a;
        r.addr = {o2, o1};
        r.am = 16'hffff;
        r.cyc = CYC_6;
      end
      OP_ACCUM_BIT_CLEAR, OP_ACCUM_BIT_SET: r.acc[o1[2:0]] = ~op[5];
      OP_CARRY_CLEAR, OP_CARRY_SET: r.psw[FLAG_C] = op[7];
      OP_PAGE_FLAG_CLEAR, OP_PAGE_FLAG_SET: r.psw[FLAG_G] = op[7];
      OP_OVERFLOW_CLEAR: r.psw = p & 8'hb7;
      OP_BRANCH_CARRY_LOW, OP_BRANCH_CARRY_HIGH: tk = p[FLAG_C] == op[7];
      OP_BRANCH_NONZERO, BZ: tk = p[FLAG_Z] == op[7];
      OP_BRANCH_NEGATIVE, OP_BRANCH_POSITIVE: tk = p[FLAG_N] == op[7];
      8'b????_0001:
      begin
        r.we = 1'b1;
        r.wd[op[7:5]] = ~op[4];
        r.addr = dp;
        r.am = 16'hffff;
        r.cyc = CYC_4;
      end
      8'b????_0010: tk = a[op[7:5]] ^ op[4];
      8'b????_0011:
      begin
        tk = m[op[7:5]] ^ op[4];
        rel = o2;
        r.addr = dp;
        r.am = 16'hffff;
        r.cyc = tk ? CYC_7 : CYC_5;
      end
      default: r.ill = 1'b1;
    endcase
    // one-byte flag ops and two-byte branches share the 0 low nibble; bit 4 parts them
    casez (op)
      8'b???0_0000: len = LEN_1;
      8'b???1_0000, 8'b????_0001, 8'b????_0010, OP_ACCUM_BIT_CLEAR, OP_ACCUM_BIT_SET: len = LEN_2;
      default: ;
    endcase
    if (op[3:0] == 4'h0 || op == OP_ACCUM_BIT_CLEAR || op == OP_ACCUM_BIT_SET || op[3:0] == 4'h2 || r.ill)
    begin
      r.am = 16'h0000;
      r.cyc = op[3:0] == 4'h2 ? (tk ? CYC_6 : CYC_4) : (tk ? CYC_4 : CYC_2);
    end
    r.pc = pc + 16'(len) + (tk ? {{8{rel[7]}}, rel} : 16'h0000);
    return r;
  endfunction : model

  // ------------------------------
  // checking and transfer tasks
  // ------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    n_checks++;
    if (got !== want)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, want);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // caller stands at a rising edge; returns at the edge where o_busy may fall
  task automatic run(input logic [7:0] op, o1, o2, a, p, m, input logic [15:0] pc, input bit poke);
    exp_type r;
    int n;
    r = model(op, o1, o2, a, p, m, pc);
    i_opcode <= op;
    i_operand1 <= o1;
    i_operand2 <= o2;
    i_acc <= a;
    i_psw <= p;
    i_mem_data <= m;
    i_pc <= pc;
    i_start <= 1'b1;
    @(negedge i_core_clk);
    check(16'(o_busy), 16'h0000);
    @(posedge i_core_clk);
    i_start <= 1'b0;
    for (n = 1; n <= 12; n++)
    begin
      @(negedge i_core_clk);
      if (o_done === 1'b1)
        break;
      @(posedge i_core_clk);
      // a start while busy must be ignored
      i_start <= poke && n == 1 && r.cyc >= CYC_4;
      i_opcode <= OP_CARRY_SET;
    end
    check(16'(n), 16'(r.cyc));
    check(16'(o_busy), 16'h0001);
    check(16'(o_illegal), 16'(r.ill));
    check(16'(o_acc), 16'(r.acc));
    check(16'(o_psw), 16'(r.psw));
    if (!r.ill)
      check(o_pc, r.pc);
    check(16'(o_mem_we), 16'(r.we));
    if (r.we)
      check(16'(o_mem_wdata), 16'(r.wd));
    if (r.am != 16'h0000)
      check(o_mem_addr & r.am, r.addr);
    @(posedge i_core_clk);
  endtask : run

  always @(posedge i_core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      errors++;
      give_verdict();
    end
  end

  // ------------------------------
  // stimulus
  // ------------------------------
  initial
  begin
    void'($urandom(32'hbcc94be8));
    repeat (8) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(posedge i_core_clk);
    run(OP_BRANCH_CARRY_LOW, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 16'hfffe, 1'b0);
    run(BZ, 8'h80, 8'h00, 8'h00, 8'h02, 8'h00, 16'h0010, 1'b1);
    run(8'hf3, 8'h44, 8'hfe, 8'h00, 8'h20, 8'h80, 16'h1234, 1'b0);
    run(OP_TEST_AND_SET, 8'h10, 8'h02, 8'h5a, 8'h00, 8'h5a, 16'h0200, 1'b1);
    run(8'h00, 8'h00, 8'h00, 8'h33, 8'h81, 8'h00, 16'h0300, 1'b0);
    for (k = 0; k < 8; k++)
      run(OPS[k % 4], 8'h34, {3'h5, k[2], 4'h2}, 8'h00, 8'h01, 8'h20, 16'h0100, 1'b0);
    for (k = 0; k < 400; k++)
    begin
      op = OPS[$urandom_range(20, 0)];
      if (k % 3 == 1)
        op = {3'($urandom), 1'($urandom), 2'b00, 2'($urandom_range(3, 1))};
      if (k % 11 == 5)
        op = k % 2 == 1 ? OP_BRANCH_NEGATIVE : OP_BRANCH_POSITIVE;
      o2 = 8'($urandom);
      if (op == OP_MEMORY_BIT_INVERT || op == OP_STORE_CARRY)
        o2[4] = 1'b0;
      run(op, 8'($urandom), o2, 8'($urandom), 8'($urandom), 8'($urandom), 16'($urandom), k % 7 == 3);
    end
    give_verdict();
  end
endmodule : bit_ops_branch_unit_bench
`default_nettype wire
